//--- core/irmr_pkg.sv
// package of constants, types and state record for the ir manchester receiver
package irmr_pkg;

	// ==========================================================
	// register word offsets (byte addresses)
	localparam logic [7:0] IRMR_OFF_CTRL = 8'h00;
	localparam logic [7:0] IRMR_OFF_DTHR = 8'h04;
	localparam logic [7:0] IRMR_OFF_GTHR = 8'h08;
	localparam logic [7:0] IRMR_OFF_STAT = 8'h0C;
	localparam logic [7:0] IRMR_OFF_SHIFT = 8'h10;
	localparam logic [7:0] IRMR_OFF_RDATA = 8'h14;

	// ==========================================================
	// control word fields
	localparam int IRMR_CTRL_EN = 0;
	localparam int IRMR_CTRL_FMT = 1;
	localparam int IRMR_CTRL_ORDER = 2;
	localparam int IRMR_CTRL_PER = 4;
	localparam int IRMR_CTRL_DPC = 8;
	localparam int IRMR_CTRL_GPC = 12;

	// threshold word fields, five bits each
	localparam int IRMR_THR_W = 5;
	localparam int IRMR_DTHR_D0L = 0;
	localparam int IRMR_DTHR_D0H = 8;
	localparam int IRMR_DTHR_D1L = 16;
	localparam int IRMR_DTHR_D1H = 24;
	localparam int IRMR_GTHR_GL = 0;
	localparam int IRMR_GTHR_GH = 8;

	// status word fields
	localparam int IRMR_STAT_FULL = 0;
	localparam int IRMR_STAT_ERR = 1;
	localparam int IRMR_STAT_END = 2;
	localparam int IRMR_STAT_GOK = 3;
	localparam int IRMR_STAT_HOLD = 4;
	localparam int IRMR_STAT_BCNT = 8;

	// ==========================================================
	// timing constants
	localparam logic [5:0] IRMR_PTC_MAX = 6'h3F;
	localparam logic [1:0] IRMR_NORMAL_BITS = 2'h3;
	localparam logic [2:0] IRMR_BYTE_LAST = 3'h7;
	localparam int IRMR_PRE_W = 12;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		IRMR_IDLE,
		IRMR_GUIDE,
		IRMR_LEAD,
		IRMR_BIT,
		IRMR_HOLD
	} irmr_st_type;

	// stretch stage of format E
	typedef enum logic [1:0] {
		IRMR_STG_NORMAL,
		IRMR_STG_HALF,
		IRMR_STG_DONE
	} irmr_stg_type;

	typedef struct packed {
		logic [4:0] d0l;
		logic [4:0] d0h;
		logic [4:0] d1l;
		logic [4:0] d1h;
		logic [4:0] gl;
		logic [4:0] gh;
	} irmr_thr_type;

	typedef struct packed {
		logic en;
		logic fmt_e;
		logic order;
		logic [2:0] per;
		logic [1:0] dpc;
		logic [1:0] gpc;
	} irmr_cfg_type;

	typedef struct packed {
		logic full;
		logic err;
		logic reception_end_flag;
		logic gok;
		logic hold;
	} irmr_flag_type;

	typedef struct packed {
		irmr_st_type st;
		irmr_stg_type stage;
		logic ack;
		logic [31:0] dat;
		irmr_cfg_type cfg;
		irmr_thr_type thr;
		irmr_flag_type flg;
		logic [IRMR_PRE_W-1:0] pre;
		logic [5:0] ptc;
		logic half;
		logic [1:0] ncnt;
		logic ir_d;
		logic s_prev;
		logic s1;
		logic first;
		logic late;
		logic [7:0] sft;
		logic [7:0] rdat;
		logic [7:0] bcnt;
	} irmr_state_type;

endpackage

//--- core/irmr_receiver.sv
// manchester infrared receiver (formats D and E) with a wishbone slave
//
// Contract
// - four timing points from programmed thresholds
// - timing four at (data1 high plus one)
// - sample at timings one and three
// - format D rising edge clears shift, count
// - decode at timing two, first bit high
// - shift bits, every eighth moves byte out
// - format D error flags, idles for edge
// - format D edge after timing three restarts
// - format D end sets flags, read resumes
// - format E guide rising-to-rising window check
// - guide ok clears counter, shift, count
// - leading phase needs edge before timing three
// - format E error flags, idles for guide
// - format E edge after timing three restarts
// - fourth bit doubles the time base length (half rate)
// - next bit restores full-rate time base
// - following phase needs edge before timing three
// - then normal cycles until reception end
// - format E end sets flags, read resumes
// - bit order select chooses lsb or msb
// - time base is 2^(period plus count) clocks
// - bit counter counts every decoded bit
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns

module irmr_receiver
	import irmr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ir_i
);

	// ==========================================================
	// helpers

	// time base length in clocks minus one; half rate doubles it
	function automatic logic [IRMR_PRE_W-1:0] tb_limit(
		input logic [2:0] per,
		input logic [1:0] cnt,
		input logic half
	);
		logic [3:0] sh;
		logic [IRMR_PRE_W-1:0] one;
		sh = 4'({1'b0, per}) + 4'({2'b00, cnt}) + 4'({3'b000, half});
		one = {{(IRMR_PRE_W-1){1'b0}}, 1'b1};
		tb_limit = (one << sh) - one;
	endfunction

	// a threshold value n stands for n plus one periods
	function automatic logic [5:0] thr_cnt(input logic [4:0] t);
		thr_cnt = {1'b0, t} + 6'h01;
	endfunction

	function automatic logic [31:0] wb_merge(
		input logic [31:0] old,
		input logic [31:0] wr,
		input logic [3:0] sel
	);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		wb_merge = m;
	endfunction

	function automatic logic [7:0] shift_in(
		input logic [7:0] s,
		input logic b,
		input logic msb_first
	);
		if (msb_first) begin
			shift_in = {s[6:0], b};
		end else begin
			shift_in = {b, s[7:1]};
		end
	endfunction

	// ==========================================================
	// state

	irmr_state_type r;
	irmr_state_type n;

	logic req;
	logic rd_go;
	logic wr_go;
	logic edge_seen;
	logic rise;
	logic tick;
	logic [5:0] inc;
	logic at1;
	logic at2;
	logic at3;
	logic at4;
	logic restart;
	logic ok;
	logic dbit;
	logic [7:0] shifted;
	logic [31:0] ctrl_w;
	logic [31:0] dthr_w;
	logic [31:0] gthr_w;
	logic [31:0] stat_w;
	logic [31:0] mw;
	irmr_flag_type fset;
	irmr_flag_type fclr;

	always_comb begin
		n = r;
		n.ack = 1'b0;
		restart = 1'b0;
		ok = 1'b0;
		dbit = 1'b0;
		shifted = r.sft;
		fset = '0;
		fclr = '0;
		mw = '0;

		// register images
		ctrl_w = '0;
		ctrl_w[IRMR_CTRL_EN] = r.cfg.en;
		ctrl_w[IRMR_CTRL_FMT] = r.cfg.fmt_e;
		ctrl_w[IRMR_CTRL_ORDER] = r.cfg.order;
		ctrl_w[IRMR_CTRL_PER +: 3] = r.cfg.per;
		ctrl_w[IRMR_CTRL_DPC +: 2] = r.cfg.dpc;
		ctrl_w[IRMR_CTRL_GPC +: 2] = r.cfg.gpc;
		dthr_w = '0;
		dthr_w[IRMR_DTHR_D0L +: IRMR_THR_W] = r.thr.d0l;
		dthr_w[IRMR_DTHR_D0H +: IRMR_THR_W] = r.thr.d0h;
		dthr_w[IRMR_DTHR_D1L +: IRMR_THR_W] = r.thr.d1l;
		dthr_w[IRMR_DTHR_D1H +: IRMR_THR_W] = r.thr.d1h;
		gthr_w = '0;
		gthr_w[IRMR_GTHR_GL +: IRMR_THR_W] = r.thr.gl;
		gthr_w[IRMR_GTHR_GH +: IRMR_THR_W] = r.thr.gh;
		stat_w = '0;
		stat_w[IRMR_STAT_FULL] = r.flg.full;
		stat_w[IRMR_STAT_ERR] = r.flg.err;
		stat_w[IRMR_STAT_END] = r.flg.reception_end_flag;
		stat_w[IRMR_STAT_GOK] = r.flg.gok;
		stat_w[IRMR_STAT_HOLD] = r.flg.hold;
		stat_w[IRMR_STAT_BCNT +: 8] = r.bcnt;

		// ==========================================================
		// wishbone slave: answer one cycle after the request,
		// act on the edge at which the master sees ack
		req = wb_cyc_i & wb_stb_i;
		rd_go = req & r.ack & ~wb_we_i;
		wr_go = req & r.ack & wb_we_i;
		if (req & ~r.ack) begin
			n.ack = 1'b1;
		end
		// load read data only on reads: it stands until the next read
		if (req & ~r.ack & ~wb_we_i) begin
			case (wb_adr_i)
				IRMR_OFF_CTRL: n.dat = ctrl_w;
				IRMR_OFF_DTHR: n.dat = dthr_w;
				IRMR_OFF_GTHR: n.dat = gthr_w;
				IRMR_OFF_STAT: n.dat = stat_w;
				IRMR_OFF_SHIFT: n.dat = {24'h000000, r.sft};
				IRMR_OFF_RDATA: n.dat = {24'h000000, r.rdat};
				default: n.dat = 32'h00000000;
			endcase
		end
		if (wr_go) begin
			case (wb_adr_i)
				IRMR_OFF_CTRL: begin
					mw = wb_merge(ctrl_w, wb_dat_i, wb_sel_i);
					n.cfg.en = mw[IRMR_CTRL_EN];
					n.cfg.fmt_e = mw[IRMR_CTRL_FMT];
					n.cfg.order = mw[IRMR_CTRL_ORDER];
					n.cfg.per = mw[IRMR_CTRL_PER +: 3];
					n.cfg.dpc = mw[IRMR_CTRL_DPC +: 2];
					n.cfg.gpc = mw[IRMR_CTRL_GPC +: 2];
				end
				IRMR_OFF_DTHR: begin
					mw = wb_merge(dthr_w, wb_dat_i, wb_sel_i);
					n.thr.d0l = mw[IRMR_DTHR_D0L +: IRMR_THR_W];
					n.thr.d0h = mw[IRMR_DTHR_D0H +: IRMR_THR_W];
					n.thr.d1l = mw[IRMR_DTHR_D1L +: IRMR_THR_W];
					n.thr.d1h = mw[IRMR_DTHR_D1H +: IRMR_THR_W];
				end
				IRMR_OFF_GTHR: begin
					mw = wb_merge(gthr_w, wb_dat_i, wb_sel_i);
					n.thr.gl = mw[IRMR_GTHR_GL +: IRMR_THR_W];
					n.thr.gh = mw[IRMR_GTHR_GH +: IRMR_THR_W];
				end
				IRMR_OFF_STAT: begin
					// write one to clear; hold only clears by reading shift
					mw = wb_merge(32'h00000000, wb_dat_i, wb_sel_i);
					fclr.full = mw[IRMR_STAT_FULL];
					fclr.err = mw[IRMR_STAT_ERR];
					fclr.reception_end_flag = mw[IRMR_STAT_END];
					fclr.gok = mw[IRMR_STAT_GOK];
				end
				default: begin
				end
			endcase
		end

		// ==========================================================
		// time base and pulse time counter
		edge_seen = ir_i ^ r.ir_d;
		rise = ir_i & ~r.ir_d;
		n.ir_d = ir_i;
		if (r.st == IRMR_GUIDE) begin
			tick = (r.pre == tb_limit(r.cfg.per, r.cfg.gpc, 1'b0));
		end else begin
			tick = (r.pre == tb_limit(r.cfg.per, r.cfg.dpc, r.half));
		end
		n.pre = tick ? '0 : r.pre + 1'b1;
		inc = (r.ptc == IRMR_PTC_MAX) ? r.ptc : r.ptc + 6'h01;
		if (tick) begin
			n.ptc = inc;
		end
		at1 = tick && (inc == thr_cnt(r.thr.d0l));
		at2 = tick && (inc == thr_cnt(r.thr.d0h));
		at3 = tick && (inc == thr_cnt(r.thr.d1l));
		at4 = tick && (inc == thr_cnt(r.thr.d1h));

		// ==========================================================
		// receive sequencer
		case (r.st)
			IRMR_IDLE: begin
				n.late = 1'b0;
				if (r.cfg.en && rise) begin
					restart = 1'b1;
					if (r.cfg.fmt_e) begin
						n.st = IRMR_GUIDE;
					end else begin
						n.sft = '0;
						n.bcnt = '0;
						n.first = 1'b1;
						n.half = 1'b0;
						n.st = IRMR_BIT;
					end
				end
			end
			IRMR_GUIDE: begin
				if (rise) begin
					// a guide out of its window restarts timing here
					restart = 1'b1;
					if (r.ptc >= thr_cnt(r.thr.gl) &&
						r.ptc < thr_cnt(r.thr.gh)) begin
						fset.gok = 1'b1;
						n.sft = '0;
						n.bcnt = '0;
						n.first = 1'b0;
						n.half = 1'b0;
						n.ncnt = '0;
						n.stage = IRMR_STG_NORMAL;
						n.late = 1'b0;
						n.st = IRMR_LEAD;
					end
				end
			end
			IRMR_LEAD: begin
				if (at1) begin
					n.s_prev = ir_i;
					n.late = 1'b1;
				end
				if (r.late && edge_seen) begin
					restart = 1'b1;
					n.late = 1'b0;
					n.st = IRMR_BIT;
				end else if (at3) begin
					fset.err = 1'b1;
					n.st = IRMR_IDLE;
				end
			end
			IRMR_BIT: begin
				if (at1) begin
					n.s1 = ir_i;
				end
				if (at2) begin
					if (r.first) begin
						ok = r.s1;
						dbit = 1'b1;
					end else begin
						ok = (r.s_prev != r.s1);
						dbit = r.s1;
					end
					if (!ok) begin
						fset.err = 1'b1;
						n.st = IRMR_IDLE;
					end else begin
						n.first = 1'b0;
						shifted = shift_in(r.sft, dbit, r.cfg.order);
						n.bcnt = r.bcnt + 8'h01;
						if (r.bcnt[2:0] == IRMR_BYTE_LAST) begin
							n.rdat = shifted;
							n.sft = '0;
							fset.full = 1'b1;
						end else begin
							n.sft = shifted;
						end
						if (r.cfg.fmt_e &&
							r.stage == IRMR_STG_NORMAL &&
							r.ncnt == IRMR_NORMAL_BITS) begin
							n.half = 1'b1;
							n.stage = IRMR_STG_HALF;
							restart = 1'b1;
							n.st = IRMR_LEAD;
						end else if (r.cfg.fmt_e &&
							r.stage == IRMR_STG_HALF) begin
							n.half = 1'b0;
							n.stage = IRMR_STG_DONE;
							restart = 1'b1;
							n.st = IRMR_LEAD;
						end else if (r.ncnt != IRMR_NORMAL_BITS) begin
							n.ncnt = r.ncnt + 2'h1;
						end
					end
				end
				if (at3 && r.st == n.st) begin
					n.s_prev = ir_i;
					n.late = 1'b1;
				end
				if (r.late && edge_seen) begin
					// mid-bit edge: next bit cycle
					restart = 1'b1;
					n.late = 1'b0;
				end else if (r.late && at4) begin
					fset.reception_end_flag = 1'b1;
					fset.hold = 1'b1;
					n.late = 1'b0;
					n.st = IRMR_HOLD;
				end
			end
			IRMR_HOLD: begin
				// suspended until software reads the shift register
				n.late = 1'b0;
			end
			default: begin
				n.st = IRMR_IDLE;
			end
		endcase

		if (restart) begin
			n.ptc = '0;
			n.pre = '0;
		end

		// reading the shift register resumes reception
		if (rd_go && wb_adr_i == IRMR_OFF_SHIFT) begin
			fclr.hold = 1'b1;
			if (r.st == IRMR_HOLD) begin
				n.st = IRMR_IDLE;
			end
		end
		if (!r.cfg.en) begin
			n.st = IRMR_IDLE;
		end

		// a hardware set in the same cycle as a clear wins
		n.flg = (r.flg & ~fclr) | fset;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;

endmodule

//--- test/irmr_receiver_sva.sv
// bus timing and read-back shape checks for the ir receiver
`timescale 1ns/1ns
module irmr_receiver_sva
	import irmr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic ir_i
);
	// ==========================================================
	// helpers
	logic req;
	logic rd;
	logic mapped;
	assign req = wb_cyc_i && wb_stb_i;
	assign rd = wb_ack_o && !wb_we_i;
	assign mapped = wb_adr_i inside {IRMR_OFF_CTRL, IRMR_OFF_DTHR,
		IRMR_OFF_GTHR, IRMR_OFF_STAT, IRMR_OFF_SHIFT, IRMR_OFF_RDATA};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ==========================================================
	// assertions
	a_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(req))
		else $error("ack without request");
	a_dat_hold: assert property (!rd |-> $stable(wb_dat_o))
		else $error("read data changed outside a read answer");
	a_shift_byte: assert property (rd && wb_adr_i == IRMR_OFF_SHIFT
		|-> wb_dat_o[31:8] == 24'h0)
		else $error("shift read wider than a byte");
	a_rdata_byte: assert property (rd && wb_adr_i == IRMR_OFF_RDATA
		|-> wb_dat_o[31:8] == 24'h0)
		else $error("byte read wider than a byte");
	a_stat_resv: assert property (rd && wb_adr_i == IRMR_OFF_STAT
		|-> wb_dat_o[31:16] == 16'h0 && wb_dat_o[7:5] == 3'h0)
		else $error("status reserved bits set");
	a_unmapped_zero: assert property (rd && !mapped
		|-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");

	cover property (rd && wb_adr_i == IRMR_OFF_RDATA);
	cover property (rd && wb_adr_i == IRMR_OFF_STAT && wb_dat_o[1]);
	cover property (rd && wb_adr_i == IRMR_OFF_STAT && wb_dat_o[3]);
endmodule

bind irmr_receiver irmr_receiver_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ir_i(ir_i));

//--- test/irmr_ir_source.sv
// demodulated remote-control signal source, idle low
`timescale 1ns/1ns
module irmr_ir_source #(
	parameter int HALF = 10
) (
	input wire logic clk_i,
	output logic ir_o
);
	// ==========================================================
	// waveform tasks
	initial ir_o = 1'h0;
	task automatic hold_lvl(input logic v, input int n);
		ir_o <= v;
		repeat (n) @(posedge clk_i);
	endtask
	// each bit: inverse half then value half; seq[0] goes first;
	// bit number wide lasts twice as long (the stretched bit of format e)
	task automatic frame(input logic [15:0] seq, input int n,
		input int wide);
		int w;
		for (int i = 0; i < n; i++) begin
			w = (i == wide) ? 2 * HALF : HALF;
			hold_lvl(!seq[i], w);
			hold_lvl(seq[i], w);
		end
		// silence long past timing four, then released line falls low
		repeat (40) @(posedge clk_i);
		hold_lvl(1'h0, 4);
	endtask
	// guide of 15 rising to rising; the caller drives the line after it
	task automatic guide();
		hold_lvl(1'h1, 7);
		hold_lvl(1'h0, 8);
	endtask
endmodule

//--- test/irmr_receiver_tb.sv
// register-level testbench for the ir receiver
`timescale 1ns/1ns
module irmr_receiver_tb;
	import irmr_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic we = 1'h0;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic [31:0] rdat;
	logic ack;
	logic ir;
	logic [31:0] q;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;

	always #4 clk_i = ~clk_i;

	irmr_receiver dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .ir_i(ir));
	irmr_ir_source src (.clk_i(clk_i), .ir_o(ir));

	// ==========================================================
	// tasks
	task stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		sel <= 4'hF;
		adr <= a;
		we <= w;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'h1) @(posedge clk_i);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		sel <= 4'h0;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		xfer(a, 1'h0, 32'h0);
		check(q & m, e);
	endtask

	// ==========================================================
	// tests
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		rd_chk(IRMR_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rd_chk(IRMR_OFF_STAT, 32'hFFFFFFFF, 32'h0);
		xfer(8'h18, 1'h1, 32'hFFFFFFFF);
		rd_chk(8'h18, 32'hFFFFFFFF, 32'h0);
		$display("test reset_values done");

		xfer(IRMR_OFF_DTHR, 1'h1, 32'h150E0904);
		rd_chk(IRMR_OFF_DTHR, 32'hFFFFFFFF, 32'h150E0904);
		xfer(IRMR_OFF_CTRL, 1'h1, 32'h1);
		// a wide index of 16 means no stretched bit
		src.frame(16'h05A5, 11, 16);
		rd_chk(IRMR_OFF_RDATA, 32'hFF, 32'hA5);
		rd_chk(IRMR_OFF_STAT, 32'h71F, 32'h315);
		rd_chk(IRMR_OFF_SHIFT, 32'hFF, 32'hA0);
		rd_chk(IRMR_OFF_STAT, 32'h10, 32'h0);
		xfer(IRMR_OFF_STAT, 1'h1, 32'hF);
		rd_chk(IRMR_OFF_STAT, 32'hF, 32'h0);
		$display("test lsb_frame done");

		xfer(IRMR_OFF_CTRL, 1'h1, 32'h5);
		src.frame(16'h000D, 8, 16);
		rd_chk(IRMR_OFF_RDATA, 32'hFF, 32'hB0);
		xfer(IRMR_OFF_SHIFT, 1'h0, 32'h0);
		xfer(IRMR_OFF_STAT, 1'h1, 32'hF);
		$display("test msb_frame done");

		xfer(IRMR_OFF_CTRL, 1'h1, 32'h1);
		src.hold_lvl(1'h1, 3);
		src.hold_lvl(1'h0, 40);
		rd_chk(IRMR_OFF_STAT, 32'hF, 32'h2);
		xfer(IRMR_OFF_STAT, 1'h1, 32'hF);
		src.frame(16'h000D, 8, 16);
		rd_chk(IRMR_OFF_RDATA, 32'hFF, 32'h0D);
		rd_chk(IRMR_OFF_STAT, 32'h3, 32'h1);
		xfer(IRMR_OFF_SHIFT, 1'h0, 32'h0);
		xfer(IRMR_OFF_STAT, 1'h1, 32'hF);
		$display("test error_frame done");

		xfer(IRMR_OFF_GTHR, 1'h1, 32'h1309);
		xfer(IRMR_OFF_CTRL, 1'h1, 32'h3);
		src.guide();
		src.hold_lvl(1'h1, 30);
		src.hold_lvl(1'h0, 4);
		rd_chk(IRMR_OFF_STAT, 32'hF, 32'hA);
		xfer(IRMR_OFF_STAT, 1'h1, 32'hF);
		$display("test guide done");

		// first bit follows the guide low, so it must be a zero;
		// bit four is the stretched one after the rate halves
		src.guide();
		src.frame(16'h0096, 8, 4);
		rd_chk(IRMR_OFF_RDATA, 32'hFF, 32'h96);
		rd_chk(IRMR_OFF_STAT, 32'hFF1F, 32'h081D);
		rd_chk(IRMR_OFF_SHIFT, 32'hFF, 32'h0);
		rd_chk(IRMR_OFF_STAT, 32'h10, 32'h0);
		$display("test format_e_frame done");
		stop_test();
	end
endmodule
